// ===== mpr_consts.svh
// Constants of the mode page responder: addresses, page codes, byte offsets and values
`ifndef MPR_CONSTS_SVH
`define MPR_CONSTS_SVH

// Register byte addresses
`define MPR_ADDR_REQ     12'h000
`define MPR_ADDR_STAT    12'h004
`define MPR_ADDR_SRC     12'h008
`define MPR_ADDR_TEXT0   12'h040
`define MPR_ADDR_TEXTN   12'h08C

// Request word fields
`define MPR_REQ_PC_RNG    5:0
`define MPR_REQ_ALLOC_RNG 15:8

// Status word bits
`define MPR_STAT_BUSY 0
`define MPR_STAT_DONE 1
`define MPR_STAT_BAD  2

// Display line source flag field
`define MPR_SRC_RNG 3:0

// Text memory geometry
`define MPR_TEXT_BYTES 7'd80
`define MPR_TEXT_W0    6'h10

// Page codes
`define MPR_CODE_GEO 8'h1E
`define MPR_CODE_CAP 8'h1F
`define MPR_CODE_DSP 8'h22
`define MPR_CODE_ALL 8'h3F
`define MPR_PS_FLAG  8'h80

// Parameter list lengths
`define MPR_LEN_GEO 8'h02
`define MPR_LEN_CAP 8'h12
`define MPR_LEN_DSP 8'h52

// Capability values
`define MPR_STORE_CAP   8'h0F
`define MPR_PAIR_PICKER 8'h0E
`define MPR_PAIR_SHELF  8'h0F
`define MPR_PAIR_MAIL   8'h0B
`define MPR_PAIR_DRIVE  8'h0F
`define MPR_SRC_PICKER  2'd0
`define MPR_SRC_SHELF   2'd1
`define MPR_SRC_MAIL    2'd2
`define MPR_SRC_DRIVE   2'd3

// Sizes in bytes
`define MPR_HDR_LEN  7'd4
`define MPR_GEO_SIZE 7'd4
`define MPR_CAP_SIZE 7'd20
`define MPR_DSP_SIZE 7'd84

// Byte offsets inside a page, and capability rows compared against offset bits 6..2
`define MPR_OFF_CODE   7'd0
`define MPR_OFF_LEN    7'd1
`define MPR_OFF_B2     7'd2
`define MPR_OFF_B3     7'd3
`define MPR_DSP_TEXT0  7'd4
`define MPR_CAP_MOVE_ROW 5'd1
`define MPR_CAP_XCHG_ROW 5'd3

`endif

// ===== mpr_initiator_model.sv
// Initiator model that takes the response byte stream, with an optional stall mode
`timescale 1ns/100ps
`default_nettype none

module mpr_initiator_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       slow,
  input  wire logic       pg_valid,
  input  wire logic [7:0] pg_byte,
  input  wire logic       pg_last,
  output var  logic       pg_ready
);
  logic [7:0] mem [0:1023];
  int         cnt;
  int         last_at;
  logic       ready_ff;

  assign pg_ready = ready_ff;

  // Store each accepted byte; in slow mode ready toggles so the sender must hold its byte
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_ff <= 1'b0;
      cnt      <= 0;
      last_at  <= -1;
    end else begin
      ready_ff <= slow ? ~ready_ff : 1'b1;
      if (pg_valid === 1'b1 && ready_ff) begin
        mem[cnt] <= pg_byte;
        cnt      <= cnt + 1;
        if (pg_last === 1'b1) begin
          last_at <= cnt;
        end
      end
    end
  end
endmodule

`default_nettype wire

// ===== mpr_mode_page_responder.sv
// Mode page responder: APB slave that streams mode sense header and read-only pages
// What this block does
// - Transport geometry page byte 0 carries page code 1Eh.
// - Transport geometry page has its savable flag cleared.
// - Transport geometry page byte 1 holds length 02h.
// - Transport geometry bytes 2 and 3 (rotate, member number) are zero.
// - Capabilities page byte 0 is code 1Fh, savable flag cleared.
// - Capabilities page byte 1 holds length 12h.
// - Capabilities byte 2 low nibble all ones, upper nibble zero.
// - Exchange bytes 12-15 use same layout and same two exclusions.
// - Display page byte 0 is code 22h with savable flag set.
// - Display page byte 1 holds length 52h.
// - Display byte 2 bits 3..0 flag lines 1..4 as host written.
// - Display lines 1-4 follow as four 20-byte text fields.
// - A four-byte header leads; byte 0 gives remaining length, rest zero.
// - Transfer stops at response end or allocation length; zero sends nothing.
`include "mpr_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module mpr_mode_page_responder import mpr_pkg::*; (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic        pready,
  output var  logic [31:0] prdata,
  output var  logic        pslverr,
  input  wire logic        pg_ready,
  output var  logic        pg_valid,
  output var  logic [7:0]  pg_byte,
  output var  logic        pg_last
);

  mpr_state_e  state_ff;
  mpr_kind_e   kind_ff;
  logic [5:0]  pc_ff;
  logic [7:0]  alloc_ff;
  logic [6:0]  tot_ff;
  logic [6:0]  cnt_ff;
  logic [6:0]  idx_ff;
  logic [3:0]  src_ff;
  logic        done_ff;
  logic        bad_ff;
  logic [6:0]  sent_ff;
  logic [7:0]  mem [0:79];

  // Total length of the response for a page selection
  function automatic logic [6:0] kind_total(input mpr_kind_e k);
    logic [6:0] r;
    r = 7'd0;
    case (k)
      MPR_K_GEO: r = `MPR_HDR_LEN + `MPR_GEO_SIZE;
      MPR_K_CAP: r = `MPR_HDR_LEN + `MPR_CAP_SIZE;
      MPR_K_DSP: r = `MPR_HDR_LEN + `MPR_DSP_SIZE;
      MPR_K_ALL: r = `MPR_HDR_LEN + `MPR_GEO_SIZE + `MPR_CAP_SIZE + `MPR_DSP_SIZE;
      default:   r = 7'd0;
    endcase
    return r;
  endfunction

  // Move and exchange row value for one source element
  function automatic logic [7:0] pair_row(input logic [1:0] src);
    logic [7:0] r;
    r = 8'h00;
    case (src)
      `MPR_SRC_PICKER: r = `MPR_PAIR_PICKER;
      `MPR_SRC_SHELF:  r = `MPR_PAIR_SHELF;
      `MPR_SRC_MAIL:   r = `MPR_PAIR_MAIL;
      `MPR_SRC_DRIVE:  r = `MPR_PAIR_DRIVE;
      default:         r = 8'h00;
    endcase
    return r;
  endfunction

  // Byte at a response position, given its page segment and local offset
  function automatic logic [7:0] page_byte(input mpr_kind_e seg, input logic [6:0] off,
                                           input logic [6:0] idx, input logic [6:0] tot,
                                           input logic [3:0] flags, input logic [7:0] txt);
    logic [7:0] r;
    r = 8'h00;
    if (idx < `MPR_HDR_LEN) begin
      if (idx == `MPR_OFF_CODE)
        r = {1'b0, tot - `MPR_HDR_LEN};
    end else begin
      case (seg)
        MPR_K_GEO: begin
          if (off == `MPR_OFF_CODE)
            r = `MPR_CODE_GEO;
          else if (off == `MPR_OFF_LEN)
            r = `MPR_LEN_GEO;
          else
            r = 8'h00;
        end
        MPR_K_CAP: begin
          if (off == `MPR_OFF_CODE)
            r = `MPR_CODE_CAP;
          else if (off == `MPR_OFF_LEN)
            r = `MPR_LEN_CAP;
          else if (off == `MPR_OFF_B2)
            r = `MPR_STORE_CAP;
          else if (off[6:2] == `MPR_CAP_MOVE_ROW)
            r = pair_row(off[1:0]);
          else if (off[6:2] == `MPR_CAP_XCHG_ROW)
            r = pair_row(off[1:0]);
          else
            r = 8'h00;
        end
        MPR_K_DSP: begin
          if (off == `MPR_OFF_CODE)
            r = `MPR_PS_FLAG | `MPR_CODE_DSP;
          else if (off == `MPR_OFF_LEN)
            r = `MPR_LEN_DSP;
          else if (off == `MPR_OFF_B2)
            r = {4'h0, flags};
          else if (off == `MPR_OFF_B3)
            r = 8'h00;
          else
            r = txt;
        end
        default: r = 8'h00;
      endcase
    end
    return r;
  endfunction

  // APB address decode
  wire        setup    = psel & ~penable;
  wire        acc      = psel & penable & pready;
  wire        hit_req  = (paddr == `MPR_ADDR_REQ);
  wire        hit_stat = (paddr == `MPR_ADDR_STAT);
  wire        hit_src  = (paddr == `MPR_ADDR_SRC);
  wire        hit_text = (paddr >= `MPR_ADDR_TEXT0) && (paddr <= `MPR_ADDR_TEXTN) && (paddr[1:0] == 2'b00);
  wire        hit_any  = hit_req | hit_stat | hit_src | hit_text;
  wire        wr       = acc & pwrite;
  wire [5:0]  word_sel = paddr[7:2] - `MPR_TEXT_W0;
  wire [6:0]  word_b0  = {word_sel[4:0], 2'b00};

  // Request decode; a request while busy is ignored
  wire [7:0]  req_pc   = {2'b00, pwdata[`MPR_REQ_PC_RNG]};
  wire [7:0]  req_alloc = pwdata[`MPR_REQ_ALLOC_RNG];
  wire        req_wr   = wr & hit_req & (state_ff == MPR_ST_IDLE);
  mpr_kind_e  req_kind;
  assign req_kind = (req_pc == `MPR_CODE_GEO) ? MPR_K_GEO :
                    (req_pc == `MPR_CODE_CAP) ? MPR_K_CAP :
                    (req_pc == `MPR_CODE_DSP) ? MPR_K_DSP :
                    (req_pc == `MPR_CODE_ALL) ? MPR_K_ALL : MPR_K_NONE;
  wire [6:0]  req_tot  = kind_total(req_kind);
  wire [6:0]  req_cnt  = (req_alloc < {1'b0, req_tot}) ? req_alloc[6:0] : req_tot;
  wire        start    = req_wr & (req_kind != MPR_K_NONE) & (req_cnt != 7'd0);

  // Stream handshake and end of transfer
  wire        take     = (state_ff == MPR_ST_SEND) & pg_valid & pg_ready;
  wire [6:0]  idx_inc  = idx_ff + 7'd1;
  wire        fin      = take & (idx_inc == cnt_ff);
  wire [6:0]  nxt_idx  = start ? 7'd0 : idx_inc;
  wire [6:0]  cur_cnt  = start ? req_cnt : cnt_ff;
  wire [6:0]  cur_tot  = start ? req_tot : tot_ff;
  mpr_kind_e  cur_kind;
  assign cur_kind = start ? req_kind : kind_ff;

  // Segment of the next byte; all pages run in ascending code order
  wire [6:0]  body     = nxt_idx - `MPR_HDR_LEN;
  wire        in_geo   = body < `MPR_GEO_SIZE;
  wire        in_cap   = body < (`MPR_GEO_SIZE + `MPR_CAP_SIZE);
  mpr_kind_e  seg;
  assign seg = (cur_kind != MPR_K_ALL) ? cur_kind :
               in_geo ? MPR_K_GEO : in_cap ? MPR_K_CAP : MPR_K_DSP;
  wire [6:0]  seg_off  = (cur_kind != MPR_K_ALL) ? body :
                         in_geo ? body :
                         in_cap ? (body - `MPR_GEO_SIZE) :
                         (body - `MPR_GEO_SIZE - `MPR_CAP_SIZE);
  wire [6:0]  text_idx = seg_off - `MPR_DSP_TEXT0;
  wire [7:0]  text_byte = (text_idx < `MPR_TEXT_BYTES) ? mem[text_idx] : 8'h00;
  wire [7:0]  nxt_byte = page_byte(seg, seg_off, nxt_idx, cur_tot, src_ff, text_byte);
  wire        nxt_last = (nxt_idx + 7'd1) == cur_cnt;

  // Sticky status, set wins over the software clear
  wire        clr_done = wr & hit_stat & pwdata[`MPR_STAT_DONE];
  wire        clr_bad  = wr & hit_stat & pwdata[`MPR_STAT_BAD];
  wire        set_done = fin | (req_wr & ~start);
  wire        set_bad  = req_wr & (req_kind == MPR_K_NONE);
  wire        nxt_done = set_done | (done_ff & ~clr_done);
  wire        nxt_bad  = set_bad | (bad_ff & ~clr_bad);

  // Read data selection
  wire [31:0] text_word = {mem[word_b0 + 7'd3], mem[word_b0 + 7'd2], mem[word_b0 + 7'd1], mem[word_b0]};
  wire [31:0] rd_data  = hit_req  ? {16'h0000, alloc_ff, 2'b00, pc_ff} :
                         hit_stat ? {29'h0000_0000, bad_ff, done_ff, (state_ff == MPR_ST_SEND)} :
                         hit_src  ? {28'h000_0000, src_ff} :
                         hit_text ? text_word : 32'h0000_0000;

  // APB answer: one wait-free access phase after every setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      prdata  <= (setup & ~pwrite) ? rd_data : 32'h0000_0000;
      pslverr <= setup & ~hit_any;
    end
  end

  // Software registers and display text
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_ff    <= 6'h00;
      alloc_ff <= 8'h00;
      src_ff   <= 4'h0;
      done_ff  <= 1'b0;
      bad_ff   <= 1'b0;
      for (int i = 0; i < 80; i++) begin
        mem[i] <= 8'h00;
      end
    end else begin
      done_ff <= nxt_done;
      bad_ff  <= nxt_bad;
      if (req_wr) begin
        pc_ff    <= pwdata[`MPR_REQ_PC_RNG];
        alloc_ff <= req_alloc;
      end
      if (wr & hit_src)
        src_ff <= pwdata[`MPR_SRC_RNG];
      if (wr & hit_text) begin
        for (int k = 0; k < 4; k++) begin
          mem[word_b0 + 7'(k)] <= pwdata[8*k +: 8];
        end
      end
    end
  end

  // Byte stream state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= MPR_ST_IDLE;
      kind_ff  <= MPR_K_NONE;
      tot_ff   <= 7'd0;
      cnt_ff   <= 7'd0;
      idx_ff   <= 7'd0;
      pg_valid <= 1'b0;
      pg_byte  <= 8'h00;
      pg_last  <= 1'b0;
    end else begin
      case (state_ff)
        MPR_ST_IDLE: begin
          if (start) begin
            state_ff <= MPR_ST_SEND;
            kind_ff  <= req_kind;
            tot_ff   <= req_tot;
            cnt_ff   <= req_cnt;
            idx_ff   <= nxt_idx;
            pg_valid <= 1'b1;
            pg_byte  <= nxt_byte;
            pg_last  <= nxt_last;
          end
        end
        MPR_ST_SEND: begin
          if (fin) begin
            state_ff <= MPR_ST_IDLE;
            pg_valid <= 1'b0;
            pg_byte  <= 8'h00;
            pg_last  <= 1'b0;
          end else if (take) begin
            idx_ff  <= nxt_idx;
            pg_byte <= nxt_byte;
            pg_last <= nxt_last;
          end
        end
        default: begin
          state_ff <= MPR_ST_IDLE;
          pg_valid <= 1'b0;
        end
      endcase
    end
  end

  // Count of accepted bytes, read only by the checks below
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      sent_ff <= 7'd0;
    else if (start)
      sent_ff <= 7'd0;
    else if (take)
      sent_ff <= sent_ff + 7'd1;
  end

  // Checks on the streamed bytes
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire geo_at  = pg_valid && (kind_ff == MPR_K_GEO);
  wire cap_at  = pg_valid && (kind_ff == MPR_K_CAP);
  wire dsp_at  = pg_valid && (kind_ff == MPR_K_DSP);
  wire all_at  = pg_valid && (kind_ff == MPR_K_ALL);

  a_geo_code_byte: assert property (geo_at && idx_ff == `MPR_HDR_LEN |->
    pg_byte == `MPR_CODE_GEO) else $error("geometry page code wrong");
  a_geo_not_savable: assert property (geo_at && idx_ff == `MPR_HDR_LEN |->
    (pg_byte & `MPR_PS_FLAG) == 8'h00) else $error("geometry savable flag set");
  a_geo_len_byte: assert property (geo_at && idx_ff == `MPR_HDR_LEN + 7'd1 |->
    pg_byte == `MPR_LEN_GEO) else $error("geometry length wrong");
  a_geo_zero_tail: assert property (geo_at && idx_ff == `MPR_HDR_LEN + 7'd2 && pg_ready |=>
    pg_byte == 8'h00 && $past(pg_byte) == 8'h00) else $error("geometry rotate or member not zero");
  a_cap_code_len: assert property (cap_at && idx_ff == `MPR_HDR_LEN && pg_ready && !pg_last |=>
    $past(pg_byte) == `MPR_CODE_CAP && pg_byte == `MPR_LEN_CAP) else $error("capability code or length wrong");
  a_cap_storage: assert property (cap_at && idx_ff == `MPR_HDR_LEN + 7'd2 |->
    pg_byte == `MPR_STORE_CAP) else $error("storage capability wrong");
  a_cap_move_rows: assert property (cap_at && idx_ff == `MPR_HDR_LEN + 7'd4 && pg_ready && !pg_last |=>
    $past(pg_byte) == `MPR_PAIR_PICKER && pg_byte == `MPR_PAIR_SHELF) else $error("move rows wrong");
  a_cap_xchg_mail: assert property (cap_at && idx_ff == `MPR_HDR_LEN + 7'd14 |->
    pg_byte == `MPR_PAIR_MAIL) else $error("exchange mail row wrong");
  a_cap_reserved: assert property (cap_at && idx_ff == `MPR_HDR_LEN + 7'd3 |->
    pg_byte == 8'h00) else $error("reserved capability byte not zero");
  a_dsp_header: assert property (dsp_at && idx_ff == `MPR_HDR_LEN && pg_ready && !pg_last |=>
    $past(pg_byte) == (`MPR_PS_FLAG | `MPR_CODE_DSP) && pg_byte == `MPR_LEN_DSP) else $error("display header wrong");
  a_dsp_line_flags: assert property (dsp_at && idx_ff == `MPR_HDR_LEN + 7'd2 |->
    pg_byte == {4'h0, src_ff}) else $error("line source flags wrong");
  a_dsp_text_first: assert property (dsp_at && idx_ff == `MPR_HDR_LEN + 7'd4 |->
    pg_byte == mem[0]) else $error("display text misplaced");
  a_hdr_length: assert property (pg_valid && idx_ff == 7'd0 |->
    pg_byte == {1'b0, tot_ff - `MPR_HDR_LEN}) else $error("header length wrong");
  a_stop_count: assert property (fin |->
    sent_ff + 7'd1 == ((alloc_ff < {1'b0, tot_ff}) ? alloc_ff[6:0] : tot_ff)) else $error("wrong byte count");
  a_zero_alloc: assert property (req_wr && req_alloc == 8'h00 |=>
    !pg_valid [*3]) else $error("zero allocation sent data");
  a_all_order: assert property (all_at && idx_ff == `MPR_HDR_LEN + `MPR_GEO_SIZE |->
    pg_byte == `MPR_CODE_CAP) else $error("all pages out of order");

  c_geo_done: cover property (fin && kind_ff == MPR_K_GEO);
  c_all_done: cover property (fin && kind_ff == MPR_K_ALL && cnt_ff == tot_ff);
  c_truncated: cover property (fin && cnt_ff < tot_ff);
  c_stalled: cover property (pg_valid && !pg_ready ##1 pg_valid && pg_ready);

endmodule

`default_nettype wire

// ===== mpr_pkg.sv
// Types shared by the mode page responder
`default_nettype none

package mpr_pkg;
  typedef enum logic [1:0] {
    MPR_ST_IDLE = 2'b00,
    MPR_ST_SEND = 2'b01
  } mpr_state_e;

  typedef enum logic [2:0] {
    MPR_K_NONE = 3'h0,
    MPR_K_GEO  = 3'h1,
    MPR_K_CAP  = 3'h2,
    MPR_K_DSP  = 3'h3,
    MPR_K_ALL  = 3'h4
  } mpr_kind_e;
endpackage

`default_nettype wire

// ===== tb.sv
// Testbench of the mode page responder: APB tasks, page requests and stream comparisons
`include "mpr_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        pg_ready;
  logic        pg_valid;
  logic [7:0]  pg_byte;
  logic        pg_last;
  logic        slow;
  int          failures;
  int          n_checks;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  exp_q[$];
  logic [7:0]  img [28] = '{8'h1E, 8'h02, 8'h00, 8'h00, 8'h1F, 8'h12, 8'h0F, 8'h00, 8'h0E, 8'h0F,
                            8'h0B, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0E, 8'h0F, 8'h0B, 8'h0F,
                            8'h00, 8'h00, 8'h00, 8'h00, 8'hA2, 8'h52, 8'h0A, 8'h00};

  mpr_mode_page_responder i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .pg_ready(pg_ready), .pg_valid(pg_valid), .pg_byte(pg_byte), .pg_last(pg_last));

  mpr_initiator_model i_host (.pclk(pclk), .presetn(presetn), .slow(slow), .pg_valid(pg_valid),
    .pg_byte(pg_byte), .pg_last(pg_last), .pg_ready(pg_ready));

  // Clock of 4 ns period
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  function automatic logic [7:0] txt(input int k);
    return 8'h30 + k[7:0];
  endfunction

  task automatic report_and_stop();
    if (failures == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      failures++;
      report_and_stop();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Request one page code, wait for done and compare the collected stream
  task automatic run(input logic [7:0] code, input logic [7:0] alloc, input logic s);
    int   i;
    int   n;
    int   base;
    logic g;
    logic c;
    logic d;
    g = (code == 8'h1E || code == 8'h3F);
    c = (code == 8'h1F || code == 8'h3F);
    d = (code == 8'h22 || code == 8'h3F);
    exp_q = '{8'h00, 8'h00, 8'h00, 8'h00};
    for (i = 0; i < 28; i++) begin
      if ((i < 4 && g) || (i >= 4 && i < 24 && c) || (i >= 24 && d)) exp_q.push_back(img[i]);
    end
    for (i = 0; d && i < 80; i++) exp_q.push_back(txt(i));
    exp_q[0] = 8'(exp_q.size() - 4);
    n = (exp_q.size() < int'(alloc)) ? exp_q.size() : int'(alloc);
    if (!(g || c || d)) n = 0;
    base = i_host.cnt;
    slow <= s;
    apb(1'b1, `MPR_ADDR_REQ, {16'h0000, alloc, 2'b00, code[5:0]});
    for (i = 0; i < 400; i++) begin
      apb(1'b0, `MPR_ADDR_STAT, 32'h0000_0000);
      if (rd[`MPR_STAT_DONE] === 1'b1) break;
    end
    if (i == 400) begin
      failures++;
      report_and_stop();
    end
    chk(rd, {29'h0, !(g || c || d), 2'b10});
    chk(32'(i_host.cnt - base), 32'(n));
    for (i = 0; i < n; i++) chk({24'h0, i_host.mem[base + i]}, {24'h0, exp_q[i]});
    if (n > 0) chk(32'(i_host.last_at), 32'(base + n - 1));
    apb(1'b1, `MPR_ADDR_STAT, 32'h0000_0006);
    apb(1'b0, `MPR_ADDR_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
  endtask

  // Main sequence
  initial begin
    presetn  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 12'h000;
    pwdata   = 32'h0000_0000;
    slow     = 1'b0;
    failures = 0;
    n_checks = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `MPR_ADDR_SRC, 32'h0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, err}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    apb(1'b1, `MPR_ADDR_SRC, 32'h0000_000A);
    for (int w = 0; w < 20; w++) begin
      apb(1'b1, `MPR_ADDR_TEXT0 + 12'(4 * w), {txt(4 * w + 3), txt(4 * w + 2), txt(4 * w + 1), txt(4 * w)});
    end
    run(8'h1E, 8'hFF, 1'b0);
    run(8'h1F, 8'hFF, 1'b1);
    run(8'h22, 8'hFF, 1'b0);
    run(8'h3F, 8'hFF, 1'b1);
    run(8'h3F, 8'h0A, 1'b0);
    run(8'h3F, 8'h6F, 1'b1);
    run(8'h1E, 8'h08, 1'b1);
    run(8'h22, 8'h01, 1'b0);
    run(8'h1F, 8'h00, 1'b0);
    run(8'h1D, 8'hFF, 1'b0);
    apb(1'b0, `MPR_ADDR_REQ, 32'h0);
    chk(rd, 32'h0000_FF1D);
    apb(1'b0, `MPR_ADDR_TEXT0, 32'h0);
    chk(rd, {txt(3), txt(2), txt(1), txt(0)});
    report_and_stop();
  end
endmodule

`default_nettype wire
